// file: core/wwc_consts.vh
`ifndef WWC_CONSTS_VH
`define WWC_CONSTS_VH

// ----------------------------------------
// register addresses (7-bit spi address)
// ----------------------------------------
`define WWC_ADDR_PROT 7'h03
`define WWC_ADDR_SETUP 7'h06
`define WWC_ADDR_SETUP_VIEW 7'h07
`define WWC_ADDR_CLOSED 7'h08
`define WWC_ADDR_CLOSED_VIEW 7'h09
`define WWC_ADDR_OPEN 7'h0a
`define WWC_ADDR_OPEN_VIEW 7'h0b
`define WWC_ADDR_SERVICE 7'h33

// ----------------------------------------
// reset values and field layout
// ----------------------------------------
`define WWC_RST_SETUP 8'h9b
`define WWC_RST_CLOSED 7'h46
`define WWC_RST_OPEN 7'h78
`define WWC_SETUP_MASK 8'hfb
`define WWC_THR_HI 7
`define WWC_THR_LO 4
`define WWC_EN_BIT 3
`define WWC_TSEL_BIT 1
`define WWC_CYC_BIT 0
`define WWC_SPAN_HI 6

// ----------------------------------------
// protection keys
// ----------------------------------------
`define WWC_KEY0 8'hab
`define WWC_KEY1 8'hef
`define WWC_KEY2 8'h56
`define WWC_KEY3 8'h12
`define WWC_LOCK_KEY 8'hdf

// ----------------------------------------
// spi frame layout
// ----------------------------------------
`define WWC_FRAME_BITS 5'h10
`define WWC_ADDR_BITS 5'h08
`define WWC_WR_BIT 15
`define WWC_ADDR_HI 14
`define WWC_ADDR_LO 8

// ----------------------------------------
// timing
// ----------------------------------------
`define WWC_CLK_PERIOD_NS 8
`define WWC_TICK_SHORT_NS 10000
`define WWC_TICK_LONG_NS 100000
`define WWC_SPAN_UNIT 13'h0032
`define WWC_ERR_MAX 4'hf

`endif

// file: core/wwc_window.v
`timescale 1ns/1ps
`default_nettype none
`include "wwc_consts.vh"

module wwc_window #(
  parameter TICK_SHORT_CYC = `WWC_TICK_SHORT_NS / `WWC_CLK_PERIOD_NS,
  parameter TICK_LONG_CYC = `WWC_TICK_LONG_NS / `WWC_CLK_PERIOD_NS
) (
  input wire clk,
  input wire reset,
  input wire enable,
  input wire tick_long,
  input wire [6:0] closed_code,
  input wire [6:0] open_code,
  input wire [3:0] threshold,
  input wire service,
  output reg window_open_q,
  output reg [3:0] err_count_q,
  output reg fail_q
);

  // ends worked out at full width, then cut to the counter width on purpose
  localparam integer TICK_SHORT_END = TICK_SHORT_CYC - 1;
  localparam integer TICK_LONG_END = TICK_LONG_CYC - 1;
  localparam [15:0] TICK_SHORT_LAST = TICK_SHORT_END[15:0];
  localparam [15:0] TICK_LONG_LAST = TICK_LONG_END[15:0];

  reg [15:0] tick_cnt_q;
  reg [12:0] span_cnt_q;
  reg tick;
  reg [12:0] span_d;

  // window length in watchdog cycles; open codes 0 and 1 both mean one unit
  function [12:0] span_len(input [6:0] code, input is_open);
    reg [12:0] c;
    begin
      c = {6'h00, code};
      if (is_open && code == 7'h00) begin
        c = 13'h0001;
      end
      span_len = c * `WWC_SPAN_UNIT;
    end
  endfunction

  // tick strobe from the selected period
  always @* begin
    tick = tick_long ? (tick_cnt_q == TICK_LONG_LAST) : (tick_cnt_q == TICK_SHORT_LAST);
    span_d = window_open_q ? span_len(open_code, 1'b1) : span_len(closed_code, 1'b0);
  end

  // ----------------------------------------
  // closed / open window sequencing
  // ----------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_cnt_q <= 16'h0000;
      span_cnt_q <= 13'h0000;
      window_open_q <= 1'b0;
      err_count_q <= 4'h0;
      fail_q <= 1'b0;
    end else if (!enable) begin
      // disabled watchdog holds idle, error history kept
      tick_cnt_q <= 16'h0000;
      span_cnt_q <= 13'h0000;
      window_open_q <= 1'b0;
      // fail keeps tracking, so a new threshold shows even while disabled
      fail_q <= (err_count_q > threshold);
    end else begin
      tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
      if (service) begin
        // service closes any window and restarts the closed one
        span_cnt_q <= 13'h0000;
        window_open_q <= 1'b0;
        tick_cnt_q <= 16'h0000;
        if (window_open_q) begin
          if (err_count_q != 4'h0) begin
            err_count_q <= err_count_q - 4'h1;
          end
        end else if (err_count_q != `WWC_ERR_MAX) begin
          err_count_q <= err_count_q + 4'h1;
        end
      end else if (span_cnt_q >= span_d) begin
        span_cnt_q <= 13'h0000;
        window_open_q <= !window_open_q;
        // open window expired without service
        if (window_open_q && err_count_q != `WWC_ERR_MAX) begin
          err_count_q <= err_count_q + 4'h1;
        end
      end else if (tick) begin
        span_cnt_q <= span_cnt_q + 13'h0001;
      end
      fail_q <= (err_count_q > threshold);
    end
  end

endmodule // wwc_window

`default_nettype wire

// file: core/wwc_top.v
// Operation
// - error threshold bits 7:4, reset nine
// - bit 3 enables watchdog, mirrored, reset on
// - bit 1 picks pin or spi service
// - bit 0 picks 10 or 100 us tick
// - closed window is code times 50 cycles
// - open window code times 50, minimum 50
// - read-only view shows setup in force
// - read-only views of window sizes in force
`timescale 1ns/1ps
`default_nettype none
`include "wwc_consts.vh"

module wwc_top #(
  parameter TICK_SHORT_CYC = `WWC_TICK_SHORT_NS / `WWC_CLK_PERIOD_NS,
  parameter TICK_LONG_CYC = `WWC_TICK_LONG_NS / `WWC_CLK_PERIOD_NS
) (
  input wire clk,
  input wire reset,
  input wire spi_sck,
  input wire spi_cs_n,
  input wire spi_mosi,
  input wire service_input_pin,
  output wire spi_miso,
  output wire spi_miso_oe,
  output wire [3:0] error_threshold,
  output wire watchdog_on,
  output wire trigger_source_select,
  output wire tick_period_select,
  output wire [6:0] closed_span_size,
  output wire [6:0] open_span_size,
  output wire service_pulse,
  output wire config_unlocked,
  output wire window_open,
  output wire [3:0] error_count,
  output wire watchdog_fail
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg sck_s1_q, sck_s2_q, sck_s3_q;
  reg cs_s1_q, cs_s2_q, cs_s3_q;
  reg mosi_s1_q, mosi_s2_q;
  reg svc_s1_q, svc_s2_q, svc_s3_q;

  // three flops per pin, two for mosi; edges are taken from the second and third only
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      mosi_s1_q <= 1'b0;
      mosi_s2_q <= 1'b0;
      svc_s1_q <= 1'b0;
      svc_s2_q <= 1'b0;
      svc_s3_q <= 1'b0;
    end else begin
      sck_s1_q <= spi_sck;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      cs_s1_q <= spi_cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      mosi_s1_q <= spi_mosi;
      mosi_s2_q <= mosi_s1_q;
      svc_s1_q <= service_input_pin;
      svc_s2_q <= svc_s1_q;
      svc_s3_q <= svc_s2_q;
    end
  end

  wire sck_rise = sck_s2_q && !sck_s3_q;
  wire sck_fall = !sck_s2_q && sck_s3_q;
  wire frame_on = !cs_s2_q;
  wire frame_end = cs_s2_q && !cs_s3_q;
  wire pin_service = svc_s2_q && !svc_s3_q;

  // ----------------------------------------
  // register state
  // ----------------------------------------
  reg [7:0] setup_sh_q, setup_act_q;
  reg [6:0] closed_sh_q, closed_act_q;
  reg [6:0] open_sh_q, open_act_q;
  reg unlocked_q;
  reg [1:0] key_step_q;
  reg service_q;

  // spi shift state
  reg [15:0] rx_q;
  reg [4:0] bit_cnt_q;
  reg [7:0] tx_q;
  reg miso_q, miso_oe_q;

  // register read decode; unmapped addresses read zero
  function [7:0] read_reg(input [6:0] a);
    begin
      case (a)
        `WWC_ADDR_PROT: read_reg = {7'h00, unlocked_q};
        `WWC_ADDR_SETUP: read_reg = setup_sh_q & `WWC_SETUP_MASK;
        `WWC_ADDR_SETUP_VIEW: read_reg = setup_act_q & `WWC_SETUP_MASK;
        `WWC_ADDR_CLOSED: read_reg = {1'b0, closed_sh_q};
        `WWC_ADDR_CLOSED_VIEW: read_reg = {1'b0, closed_act_q};
        `WWC_ADDR_OPEN: read_reg = {1'b0, open_sh_q};
        `WWC_ADDR_OPEN_VIEW: read_reg = {1'b0, open_act_q};
        default: read_reg = 8'h00;
      endcase
    end
  endfunction

  // expected key for each unlock step
  function [7:0] key_at(input [1:0] s);
    begin
      case (s)
        2'h0: key_at = `WWC_KEY0;
        2'h1: key_at = `WWC_KEY1;
        2'h2: key_at = `WWC_KEY2;
        default: key_at = `WWC_KEY3;
      endcase
    end
  endfunction

  wire [6:0] rx_addr = rx_q[`WWC_ADDR_HI:`WWC_ADDR_LO];
  // address as it stands at the 8th rising edge, last bit still on the line
  wire [6:0] cmd_addr = {rx_q[5:0], mosi_s2_q};
  wire rx_write = rx_q[`WWC_WR_BIT];
  wire [7:0] rx_data = rx_q[7:0];
  wire commit = frame_end && (bit_cnt_q == `WWC_FRAME_BITS);

  // ----------------------------------------
  // spi frame: mode 0, msb first, w/addr/data
  // ----------------------------------------
  // miso reloads after the address byte, so reads return data in the same frame
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_q <= 16'h0000;
      bit_cnt_q <= 5'h00;
      tx_q <= 8'h00;
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end else if (!frame_on) begin
      bit_cnt_q <= 5'h00;
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end else begin
      miso_oe_q <= 1'b1;
      if (sck_rise) begin
        rx_q <= {rx_q[14:0], mosi_s2_q};
        // overlong frames stop counting and are dropped at the end
        if (bit_cnt_q <= `WWC_FRAME_BITS) begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
        end
        if (bit_cnt_q == `WWC_ADDR_BITS - 5'h01) begin
          tx_q <= read_reg(cmd_addr);
          miso_q <= |(read_reg(cmd_addr) >> (`WWC_ADDR_BITS - 5'h01));
        end
      end else if (sck_fall && bit_cnt_q > `WWC_ADDR_BITS && bit_cnt_q < `WWC_FRAME_BITS) begin
        tx_q <= {tx_q[6:0], 1'b0};
        miso_q <= tx_q[6];
      end
    end
  end

  // ----------------------------------------
  // register writes and protection
  // ----------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      setup_sh_q <= `WWC_RST_SETUP;
      setup_act_q <= `WWC_RST_SETUP;
      closed_sh_q <= `WWC_RST_CLOSED;
      closed_act_q <= `WWC_RST_CLOSED;
      open_sh_q <= `WWC_RST_OPEN;
      open_act_q <= `WWC_RST_OPEN;
      unlocked_q <= 1'b0;
      key_step_q <= 2'h0;
      service_q <= 1'b0;
    end else begin
      service_q <= 1'b0;
      // service trigger: pin edge or spi write, per active selection
      if (!setup_act_q[`WWC_TSEL_BIT] && pin_service) begin
        service_q <= 1'b1;
      end
      if (commit && rx_write) begin
        case (rx_addr)
          `WWC_ADDR_SERVICE: begin
            if (setup_act_q[`WWC_TSEL_BIT]) begin
              service_q <= 1'b1;
            end
          end
          `WWC_ADDR_PROT: begin
            if (rx_data == `WWC_LOCK_KEY) begin
              // new setup takes force only when the protection is relocked
              unlocked_q <= 1'b0;
              key_step_q <= 2'h0;
              setup_act_q <= setup_sh_q;
              closed_act_q <= closed_sh_q;
              open_act_q <= open_sh_q;
            end else if (!unlocked_q) begin
              if (rx_data == key_at(key_step_q)) begin
                key_step_q <= key_step_q + 2'h1;
                unlocked_q <= (key_step_q == 2'h3);
              end else begin
                key_step_q <= 2'h0;
              end
            end
          end
          `WWC_ADDR_SETUP: begin
            if (unlocked_q) begin
              setup_sh_q <= rx_data & `WWC_SETUP_MASK;
            end
          end
          `WWC_ADDR_CLOSED: begin
            if (unlocked_q) begin
              closed_sh_q <= rx_data[`WWC_SPAN_HI:0];
            end
          end
          `WWC_ADDR_OPEN: begin
            if (unlocked_q) begin
              open_sh_q <= rx_data[`WWC_SPAN_HI:0];
            end
          end
          // the views and unmapped addresses ignore writes
          // nothing may be re-armed here, or an old service pulse would repeat
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // window timing
  // ----------------------------------------
  wwc_window #(
    .TICK_SHORT_CYC(TICK_SHORT_CYC),
    .TICK_LONG_CYC(TICK_LONG_CYC)
  ) u_window (
    .clk(clk),
    .reset(reset),
    .enable(setup_act_q[`WWC_EN_BIT]),
    .tick_long(setup_act_q[`WWC_CYC_BIT]),
    .closed_code(closed_act_q),
    .open_code(open_act_q),
    .threshold(setup_act_q[`WWC_THR_HI:`WWC_THR_LO]),
    .service(service_q),
    .window_open_q(window_open),
    .err_count_q(error_count),
    .fail_q(watchdog_fail)
  );

  // outputs straight from flops
  assign spi_miso = miso_q;
  assign spi_miso_oe = miso_oe_q;
  assign error_threshold = setup_act_q[`WWC_THR_HI:`WWC_THR_LO];
  assign watchdog_on = setup_act_q[`WWC_EN_BIT];
  assign trigger_source_select = setup_act_q[`WWC_TSEL_BIT];
  assign tick_period_select = setup_act_q[`WWC_CYC_BIT];
  assign closed_span_size = closed_act_q;
  assign open_span_size = open_act_q;
  assign service_pulse = service_q;
  assign config_unlocked = unlocked_q;

endmodule // wwc_top

`default_nettype wire

// file: verification/wwc_top_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// watchdog configuration checks
// ----
module wwc_top_props (
  input wire clk,
  input wire reset,
  input wire spi_cs_n,
  input wire spi_miso,
  input wire spi_miso_oe,
  input wire service_input_pin,
  input wire [3:0] error_threshold,
  input wire watchdog_on,
  input wire trigger_source_select,
  input wire [6:0] closed_span_size,
  input wire [6:0] open_span_size,
  input wire service_pulse,
  input wire config_unlocked,
  input wire window_open,
  input wire [3:0] error_count,
  input wire watchdog_fail
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // values in force move only when the lock write lands
  a_hold_unlocked: assert property (config_unlocked && $past(config_unlocked) |->
    $stable({error_threshold, watchdog_on, closed_span_size, open_span_size})) else $error("config moved");
  a_svc_single: assert property (service_pulse |=> !service_pulse) else $error("long service pulse");
  // pin edges must not service while spi trigger is chosen
  a_pin_ignored: assert property ((spi_cs_n && trigger_source_select)[*8] |-> !service_pulse)
    else $error("pin service while spi trigger");
  a_spi_ignored: assert property ((!trigger_source_select && !service_input_pin)[*6] |-> !service_pulse)
    else $error("service without pin edge");
  a_fail_follows: assert property (watchdog_fail == ($past(error_count) > $past(error_threshold)))
    else $error("fail flag wrong");
  a_count_step: assert property ($changed(error_count) |-> error_count == $past(error_count) + 4'h1 ||
    error_count + 4'h1 == $past(error_count)) else $error("error count jump");
  a_off_idle: assert property (!watchdog_on && !$past(watchdog_on) |-> !window_open && $stable(error_count))
    else $error("disabled watchdog active");
  // miso must go quiet once the frame has ended
  a_miso_quiet: assert property (spi_cs_n[*5] |-> !spi_miso_oe && !spi_miso) else $error("miso driven idle");
  c_service: cover property (service_pulse);
  c_fail: cover property ($rose(watchdog_fail));
  c_open: cover property ($rose(window_open));
endmodule // wwc_top_props
`default_nettype wire

// file: verification/wwc_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// controller model, spi mode 0
// ----
module wwc_spi_host (
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire spi_miso,
  output logic rd_valid,
  output logic [7:0] rd_data
);
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b1;
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end
  // one whole 16-bit frame; sck rests low, idle data line toggles so stale bits never look valid
  task automatic xfer(input logic [15:0] word, input logic note);
    integer i;
    spi_cs_n = 1'b0;
    for (i = 15; i >= 0; i--) begin
      spi_mosi = word[i];
      #62.5 spi_sck = 1'b1;
      if (i < 8) rd_data[i] = spi_miso;
      #62.5 spi_sck = 1'b0;
    end
    #62.5 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    rd_valid = note;
    #100 rd_valid = 1'b0; // keeps cs high well past 4 clocks
  endtask
endmodule // wwc_spi_host
`default_nettype wire

// file: verification/test_window_watchdog_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "wwc_consts.vh"
// ----
// bench top
// ----
module test_window_watchdog_config;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic service_input_pin = 1'b0;
  wire spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, watchdog_on, trigger_source_select;
  wire tick_period_select, service_pulse, config_unlocked, window_open, watchdog_fail, rd_valid;
  wire [3:0] error_threshold, error_count;
  wire [6:0] closed_span_size, open_span_size;
  wire [7:0] rd_data;
  logic [7:0] exp_q[$];
  logic [7:0] r;
  integer seed = 32'h7fe7;
  int failures = 0, n_checks = 0, svc_n = 0, n = 0, s0;
  // short tick counts keep the window phases a few thousand clocks long
  wwc_top #(.TICK_SHORT_CYC(4), .TICK_LONG_CYC(10)) wwc_top_inst (.clk, .reset, .spi_sck, .spi_cs_n,
    .spi_mosi, .service_input_pin, .spi_miso, .spi_miso_oe, .error_threshold, .watchdog_on,
    .trigger_source_select, .tick_period_select, .closed_span_size, .open_span_size, .service_pulse,
    .config_unlocked, .window_open, .error_count, .watchdog_fail);
  wwc_spi_host wwc_spi_host_inst (.spi_sck, .spi_cs_n, .spi_mosi, .spi_miso, .rd_valid, .rd_data);
  // 125 MHz clock
  always #4 clk = ~clk;
  // count service pulses, and compare each read with the oldest note
  always @(posedge clk) if (service_pulse === 1'b1) svc_n <= svc_n + 1;
  always @(posedge rd_valid) chk("read data", rd_data, exp_q.size() ? exp_q.pop_front() : 8'hxx);
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    wwc_spi_host_inst.xfer({1'b1, a, d}, 1'b0);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    wwc_spi_host_inst.xfer({1'b0, a, 8'h00}, 1'b1);
  endtask
  task automatic unlock;
    wr(`WWC_ADDR_PROT, `WWC_KEY0);
    wr(`WWC_ADDR_PROT, `WWC_KEY1);
    wr(`WWC_ADDR_PROT, `WWC_KEY2);
    wr(`WWC_ADDR_PROT, `WWC_KEY3);
  endtask
  task automatic cfg(input logic [7:0] s, input logic [7:0] c, input logic [7:0] o);
    unlock();
    wr(7'h06, s);
    wr(7'h08, c);
    wr(7'h0a, o);
    wr(`WWC_ADDR_PROT, `WWC_LOCK_KEY);
  endtask
  task automatic wait_open(input logic lvl);
    n = 0;
    while (window_open !== lvl) begin
      @(posedge clk);
      n++;
      if (n > 9000) begin
        failures++;
        summarize();
      end
    end
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    chk("setup out", {error_threshold, watchdog_on, 1'b0, trigger_source_select, tick_period_select}, 8'h9b);
    rd(7'h06, 8'h9b);
    rd(7'h07, 8'h9b);
    rd(7'h08, 8'h46);
    rd(7'h09, 8'h46);
    rd(7'h0a, 8'h78);
    rd(7'h0b, 8'h78);
    wr(7'h06, 8'h00);
    rd(7'h06, 8'h9b);
    r = $random(seed);
    unlock();
    chk("unlocked", config_unlocked, 8'h01);
    rd(`WWC_ADDR_PROT, 8'h01);
    wr(7'h06, r);
    wr(7'h08, r);
    rd(7'h06, r & 8'hfb);
    rd(7'h08, r & 8'h7f);
    rd(7'h07, 8'h9b);
    // threshold 0, spi trigger, 10 us tick; closed 3200 clocks, open 800
    cfg(8'h0a, 8'h10, 8'h04);
    wr(`WWC_ADDR_SERVICE, 8'h00);
    repeat (4) @(posedge clk);
    chk("count", error_count, 8'h01);
    chk("fail", watchdog_fail, 8'h01);
    chk("svc", svc_n, 8'h01);
    chk("unlocked", config_unlocked, 8'h00);
    chk("closed size", closed_span_size, 8'h10);
    chk("open size", open_span_size, 8'h04);
    chk("setup out", {error_threshold, watchdog_on, 1'b0, trigger_source_select, tick_period_select}, 8'h0a);
    rd(7'h07, 8'h0a);
    rd(7'h09, 8'h10);
    rd(7'h0b, 8'h04);
    wr(7'h07, 8'hff);
    rd(7'h07, 8'h0a);
    rd(7'h20, 8'h00);
    wait_open(1'b1);
    wr(`WWC_ADDR_SERVICE, 8'h00);
    repeat (4) @(posedge clk);
    chk("count", error_count, 8'h00);
    wait_open(1'b1);
    chk("closed len", n inside {[3170:3205]}, 8'h01);
    wait_open(1'b0);
    chk("open len", n inside {[790:805]}, 8'h01);
    repeat (4) @(posedge clk);
    chk("count", error_count, 8'h01);
    cfg(8'h08, 8'h10, 8'h04);
    s0 = svc_n;
    wr(`WWC_ADDR_SERVICE, 8'h00);
    service_input_pin <= 1'b1;
    repeat (8) @(posedge clk);
    service_input_pin <= 1'b0;
    repeat (8) @(posedge clk);
    chk("svc", svc_n - s0, 8'h01);
    // closed code 0 gives a one-clock closed window, open code 0 still 50 ticks
    cfg(8'h08, 8'h00, 8'h00);
    wait_open(1'b0);
    wait_open(1'b1);
    chk("closed len", n inside {[0:2]}, 8'h01);
    wait_open(1'b0);
    chk("open len", n inside {[195:205]}, 8'h01);
    cfg(8'h00, 8'h10, 8'h04);
    repeat (8) @(posedge clk);
    chk("on", {window_open, watchdog_on}, 8'h00);
    summarize();
  end
endmodule // test_window_watchdog_config
bind wwc_top wwc_top_props wwc_top_props_inst (.clk, .reset, .spi_cs_n, .spi_miso, .spi_miso_oe,
  .service_input_pin, .error_threshold, .watchdog_on, .trigger_source_select, .closed_span_size,
  .open_span_size, .service_pulse, .config_unlocked, .window_open, .error_count, .watchdog_fail);
`default_nettype wire
